// [verilog/edtx_pkg.sv]
// Shared constants and types for the energy-detect and TX framing block.
// Assumes one device clock; every user imports nothing and writes edtx_pkg::name.
package edtx_pkg;

	// Register byte addresses on the host register port
	localparam logic [7:0] ENERGY_CTRL_ADDR = 8'h41;
	localparam logic [7:0] LEAD_HI_ADDR = 8'h42;
	localparam logic [7:0] LEAD_LO_ADDR = 8'h43;
	localparam logic [7:0] TAIL_CFG_ADDR = 8'h44;

	// Reset values
	localparam logic [7:0] ENERGY_CTRL_RST = 8'ha0;
	localparam logic [7:0] LEAD_HI_RST = 8'h00;
	localparam logic [7:0] LEAD_LO_RST = 8'h08;
	localparam logic [7:0] TAIL_CFG_RST = 8'h12;
	localparam logic [3:0] LEAD_PATTERN_RST = 4'h5;

	// Writable bits; reserved bits of the tail register stay zero
	localparam logic [7:0] ENERGY_CTRL_WMASK = 8'hff;
	localparam logic [7:0] TAIL_CFG_WMASK = 8'h77;

	// Energy control field positions
	localparam int CALC_EN_BIT = 7;
	localparam int OUTCOME_SEL_BIT = 6;
	localparam int WIDTH_SEL_BIT = 5;
	localparam int COMPLETE_BIT = 4;
	localparam int CAPTURE_SEL_BIT = 3;
	localparam int AVG_LSB = 0;
	localparam int AVG_W = 3;

	// Tail configuration field positions
	localparam int TAIL_LEN_LSB = 4;
	localparam int TAIL_LEN_W = 3;
	localparam int TAIL_PAT_LSB = 1;
	localparam int TAIL_EN_BIT = 0;

	// Averaging codes
	localparam logic [2:0] AVG_CODE_MAX = 3'h5;
	localparam logic [2:0] AVG_FALLBACK_SHIFT = 3'h4;

	// Tail pattern codes
	localparam logic [1:0] TAIL_PAT_01 = 2'h0;
	localparam logic [1:0] TAIL_PAT_10 = 2'h1;
	localparam logic [1:0] TAIL_PAT_CRC = 2'h2;
	localparam logic [1:0] TAIL_PAT_11 = 2'h3;

	// Framing configuration handed to the bit generator
	typedef struct packed {
		logic [15:0] lead_len;
		logic [3:0] lead_pattern;
		logic [2:0] tail_len;
		logic [1:0] tail_pat;
		logic tail_en;
	} frame_cfg_t;

endpackage

// [verilog/lead_tail_gen.sv]
// Serial preamble and postamble bit generator for the TX framer.
// Assumes the framer requests one bit per bit_req_i pulse on the same clock.
`timescale 1ns/10ps

module lead_tail_gen (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Configuration and control
	input wire edtx_pkg::frame_cfg_t cfg_i,
	input wire logic lead_start_i,
	input wire logic tail_start_i,
	input wire logic [1:0] crc_tail_i,
	input wire logic bit_req_i,
	// Bit stream
	output logic bit_o,
	output logic bit_valid_o,
	output logic lead_done_o,
	output logic tail_done_o
);

	typedef enum logic [1:0] {GEN_IDLE, GEN_LEAD, GEN_TAIL} gen_phase_t;

	typedef struct packed {
		gen_phase_t phase;
		logic [16:0] remain;
		logic [1:0] idx;
		logic bit_v;
		logic valid;
		logic lead_done;
		logic tail_done;
	} gen_state_t;

	localparam gen_state_t GEN_RST = '{phase: GEN_IDLE, default: '0};

	gen_state_t state_q, state_d;

	// Postamble bit at position k of the repeating unit
	function automatic logic tail_bit(input logic [1:0] pat, input logic [1:0] crc,
			input logic [1:0] k);
		logic b;
		b = 1'b1;
		unique case (pat)
			edtx_pkg::TAIL_PAT_01: b = k[0];
			edtx_pkg::TAIL_PAT_10: b = ~k[0];
			// Last CRC pair, then its inverse
			edtx_pkg::TAIL_PAT_CRC: b = crc[~k[0]] ^ k[1];
			edtx_pkg::TAIL_PAT_11: b = 1'b1;
		endcase
		return b;
	endfunction

	// Next-state logic; starts while busy are ignored
	always_comb begin
		state_d = state_q;
		state_d.lead_done = 1'b0;
		state_d.tail_done = 1'b0;
		unique case (state_q.phase)
			GEN_IDLE: begin
				if (lead_start_i) begin
					state_d.remain = {cfg_i.lead_len, 1'b0};
					state_d.idx = 2'h0;
					state_d.bit_v = cfg_i.lead_pattern[3];
					if (cfg_i.lead_len == 16'h0000) begin
						state_d.lead_done = 1'b1;
					end else begin
						state_d.phase = GEN_LEAD;
						state_d.valid = 1'b1;
					end
				end else if (tail_start_i) begin
					state_d.remain = {13'h0000, cfg_i.tail_len, 1'b0};
					state_d.idx = 2'h0;
					state_d.bit_v = tail_bit(cfg_i.tail_pat, crc_tail_i, 2'h0);
					if (!cfg_i.tail_en || cfg_i.tail_len == 3'h0) begin
						state_d.tail_done = 1'b1;
					end else begin
						state_d.phase = GEN_TAIL;
						state_d.valid = 1'b1;
					end
				end
			end
			GEN_LEAD, GEN_TAIL: begin
				if (bit_req_i) begin
					state_d.remain = 17'(state_q.remain - 17'h00001);
					state_d.idx = 2'(state_q.idx + 2'h1);
					if (state_q.remain == 17'h00001) begin
						state_d.phase = GEN_IDLE;
						state_d.valid = 1'b0;
						state_d.lead_done = (state_q.phase == GEN_LEAD);
						state_d.tail_done = (state_q.phase == GEN_TAIL);
					end else if (state_q.phase == GEN_LEAD) begin
						state_d.bit_v = cfg_i.lead_pattern[~state_d.idx];
					end else begin
						state_d.bit_v = tail_bit(cfg_i.tail_pat, crc_tail_i, state_d.idx);
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= GEN_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state register
	assign bit_o = state_q.bit_v;
	assign bit_valid_o = state_q.valid;
	assign lead_done_o = state_q.lead_done;
	assign tail_done_o = state_q.tail_done;

endmodule

// [verilog/energy_detect_and_tx_framing_config.sv]
// Energy detection control and TX framing configuration register bank.
// Assumes the serial host interface presents decoded same-clock register strobes.
`timescale 1ns/10ps

module energy_detect_and_tx_framing_config (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port from the host interface
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Energy samples from the two channel filters
	input wire logic sample_valid_i,
	input wire logic [7:0] sample_normal_i,
	input wire logic [7:0] sample_wide_i,
	// Radio context
	input wire logic calc_halt_i,
	input wire logic quick_carrier_check_enable_i,
	input wire logic fast_check_active_i,
	input wire logic fast_check_done_i,
	input wire logic carrier_found_i,
	input wire logic sync_detected_i,
	input wire logic rx_fifo_read_i,
	// Energy value and state requests
	output logic [7:0] energy_value_o,
	output logic goto_sleep_o,
	output logic goto_tx_on_o,
	output logic keep_receiving_o,
	// TX framing
	input wire logic [3:0] lead_pattern_i,
	input wire logic lead_start_i,
	input wire logic tail_start_i,
	input wire logic [1:0] crc_tail_i,
	input wire logic bit_req_i,
	output logic tx_bit_o,
	output logic tx_bit_valid_o,
	output logic lead_done_o,
	output logic tail_done_o
);

	typedef struct packed {
		logic [7:0] energy_ctrl;
		logic [15:0] lead_len;
		logic [7:0] tail_cfg;
		logic [7:0] rdata;
		logic [12:0] acc;
		logic [5:0] cnt;
		logic [7:0] live;
		logic [7:0] held;
		logic [7:0] shown;
		logic was_running;
		logic sleep_req;
		logic tx_on_req;
		logic keep_rx_req;
	} bank_state_t;

	localparam bank_state_t BANK_RST = '{
		energy_ctrl: edtx_pkg::ENERGY_CTRL_RST,
		lead_len: {edtx_pkg::LEAD_HI_RST, edtx_pkg::LEAD_LO_RST},
		tail_cfg: edtx_pkg::TAIL_CFG_RST,
		default: '0
	};

	bank_state_t state_q, state_d;

	// Working values of the combinational process
	logic running;
	logic [7:0] sample;
	logic [12:0] sum;
	logic [2:0] shift;
	logic [7:0] ctrl_wr;
	edtx_pkg::frame_cfg_t frame_cfg;

	// Right shift that divides the sum by the averaging count
	function automatic logic [2:0] avg_shift(input logic [2:0] code);
		logic [2:0] s;
		s = code;
		if (code > edtx_pkg::AVG_CODE_MAX) begin
			s = edtx_pkg::AVG_FALLBACK_SHIFT;
		end
		return s;
	endfunction

	// Number of samples per averaged result
	function automatic logic [5:0] avg_samples(input logic [2:0] code);
		return 6'(6'h01 << avg_shift(code));
	endfunction

	// Register read data; unmapped addresses read zero
	function automatic logic [7:0] read_mux(input bank_state_t s, input logic [7:0] addr);
		logic [7:0] r;
		r = 8'h00;
		unique case (addr)
			edtx_pkg::ENERGY_CTRL_ADDR: r = s.energy_ctrl;
			edtx_pkg::LEAD_HI_ADDR: r = s.lead_len[15:8];
			edtx_pkg::LEAD_LO_ADDR: r = s.lead_len[7:0];
			edtx_pkg::TAIL_CFG_ADDR: r = s.tail_cfg & edtx_pkg::TAIL_CFG_WMASK;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// Register bank, energy averaging and quick check outcome
	always_comb begin
		state_d = state_q;
		state_d.sleep_req = 1'b0;
		state_d.tx_on_req = 1'b0;
		state_d.keep_rx_req = 1'b0;
		ctrl_wr = state_q.energy_ctrl;
		running = state_q.energy_ctrl[edtx_pkg::CALC_EN_BIT] && !calc_halt_i;
		shift = avg_shift(state_q.energy_ctrl[edtx_pkg::AVG_LSB +: edtx_pkg::AVG_W]);
		sample = sample_normal_i;
		if (fast_check_active_i && state_q.energy_ctrl[edtx_pkg::WIDTH_SEL_BIT]) begin
			sample = sample_wide_i;
		end
		sum = 13'(state_q.acc + {5'h00, sample});

		// Read data is registered, answered one cycle later
		if (reg_rd_i) begin
			state_d.rdata = read_mux(state_q, reg_addr_i);
		end

		// Fresh run starts as not complete
		if (running && !state_q.was_running) begin
			ctrl_wr[edtx_pkg::COMPLETE_BIT] = 1'b0;
		end

		// Register writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				edtx_pkg::ENERGY_CTRL_ADDR: begin
					ctrl_wr = reg_wdata_i & edtx_pkg::ENERGY_CTRL_WMASK;
				end
				edtx_pkg::LEAD_HI_ADDR: state_d.lead_len[15:8] = reg_wdata_i;
				edtx_pkg::LEAD_LO_ADDR: state_d.lead_len[7:0] = reg_wdata_i;
				edtx_pkg::TAIL_CFG_ADDR: begin
					state_d.tail_cfg = reg_wdata_i & edtx_pkg::TAIL_CFG_WMASK;
				end
				default: begin
				end
			endcase
		end

		// Averaging accumulator; stopped calculation clears partial sums
		if (!running) begin
			state_d.acc = 13'h0000;
			state_d.cnt = 6'h00;
		end else if (sample_valid_i) begin
			if (6'(state_q.cnt + 6'h01) == avg_samples(
					state_q.energy_ctrl[edtx_pkg::AVG_LSB +: edtx_pkg::AVG_W])) begin
				state_d.live = 8'(sum >> shift);
				state_d.acc = 13'h0000;
				state_d.cnt = 6'h00;
				// Completion flag set wins over clear
				ctrl_wr[edtx_pkg::COMPLETE_BIT] = 1'b1;
			end else begin
				state_d.acc = sum;
				state_d.cnt = 6'(state_q.cnt + 6'h01);
			end
		end
		state_d.energy_ctrl = ctrl_wr;
		state_d.was_running = running;

		if (sync_detected_i) begin
			state_d.held = state_d.live;
		end
		if (!state_q.energy_ctrl[edtx_pkg::CAPTURE_SEL_BIT]) begin
			state_d.shown = state_d.live;
		end else if (rx_fifo_read_i) begin
			// Captured value shown on FIFO read
			state_d.shown = state_q.held;
		end

		// Outcome only with quick check enabled
		if (fast_check_done_i && quick_carrier_check_enable_i) begin
			if (!state_q.energy_ctrl[edtx_pkg::OUTCOME_SEL_BIT]) begin
				state_d.sleep_req = !carrier_found_i;
				state_d.keep_rx_req = carrier_found_i;
			end else begin
				state_d.tx_on_req = !carrier_found_i;
				state_d.sleep_req = carrier_found_i;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= BANK_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// Framing configuration from the registers; lead pattern from the lead_pattern_i port
	always_comb begin
		frame_cfg.lead_len = state_q.lead_len;
		frame_cfg.lead_pattern = lead_pattern_i;
		frame_cfg.tail_len = state_q.tail_cfg[edtx_pkg::TAIL_LEN_LSB +: edtx_pkg::TAIL_LEN_W];
		frame_cfg.tail_pat = state_q.tail_cfg[edtx_pkg::TAIL_PAT_LSB +: 2];
		frame_cfg.tail_en = state_q.tail_cfg[edtx_pkg::TAIL_EN_BIT];
	end

	// Bit generator; its outputs are its own flops
	lead_tail_gen u_gen (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.cfg_i(frame_cfg),
		.lead_start_i(lead_start_i),
		.tail_start_i(tail_start_i),
		.crc_tail_i(crc_tail_i),
		.bit_req_i(bit_req_i),
		.bit_o(tx_bit_o),
		.bit_valid_o(tx_bit_valid_o),
		.lead_done_o(lead_done_o),
		.tail_done_o(tail_done_o)
	);

	// Outputs straight from the state register
	assign reg_rdata_o = state_q.rdata;
	assign energy_value_o = state_q.shown;
	assign goto_sleep_o = state_q.sleep_req;
	assign goto_tx_on_o = state_q.tx_on_req;
	assign keep_receiving_o = state_q.keep_rx_req;

endmodule

// [verif/edtx_sva.sv]
// Port-level checker for the energy-detect and TX framing register bank.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/10ps

module edtx_sva (
	// Clock, reset and register port
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Quick carrier check
	input wire logic quick_carrier_check_enable_i,
	input wire logic fast_check_done_i,
	input wire logic carrier_found_i,
	input wire logic goto_sleep_o,
	input wire logic goto_tx_on_o,
	input wire logic keep_receiving_o,
	// Framer
	input wire logic lead_start_i,
	input wire logic tail_start_i,
	input wire logic bit_req_i,
	input wire logic tx_bit_o,
	input wire logic tx_bit_valid_o,
	input wire logic lead_done_o,
	input wire logic tail_done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Register port: reserved bits and unmapped places
	property p_tail_rsv;
		reg_rd_i && reg_addr_i == edtx_pkg::TAIL_CFG_ADDR |=> !reg_rdata_o[7] && !reg_rdata_o[3];
	endproperty
	a_tail_rsv: assert property (p_tail_rsv) else $error("tail reserved bit set");
	property p_unmapped;
		reg_rd_i && (reg_addr_i < 8'h41 || reg_addr_i > 8'h44) |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// Quick check verdicts, one-cycle state requests
	property p_chk_off;
		fast_check_done_i && !quick_carrier_check_enable_i
			|=> !(goto_sleep_o || goto_tx_on_o || keep_receiving_o);
	endproperty
	a_chk_off: assert property (p_chk_off) else $error("request while check off");
	property p_carrier;
		fast_check_done_i && quick_carrier_check_enable_i && carrier_found_i
			|=> !goto_tx_on_o && (goto_sleep_o ^ keep_receiving_o);
	endproperty
	a_carrier: assert property (p_carrier) else $error("bad carrier verdict");
	property p_nocarrier;
		fast_check_done_i && quick_carrier_check_enable_i && !carrier_found_i
			|=> !keep_receiving_o && (goto_sleep_o ^ goto_tx_on_o);
	endproperty
	a_nocarrier: assert property (p_nocarrier) else $error("bad idle verdict");
	property p_cause;
		goto_sleep_o || goto_tx_on_o || keep_receiving_o
			|-> $past(fast_check_done_i && quick_carrier_check_enable_i);
	endproperty
	a_cause: assert property (p_cause) else $error("request without verdict");

	// Framer bit holding and completion
	property p_bit_hold;
		tx_bit_valid_o && !bit_req_i |=> tx_bit_valid_o && $stable(tx_bit_o);
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("bit moved unasked");
	property p_idle_req;
		!tx_bit_valid_o && bit_req_i && !lead_start_i && !tail_start_i |=> !tx_bit_valid_o;
	endproperty
	a_idle_req: assert property (p_idle_req) else $error("idle request started");
	property p_lead_done;
		lead_done_o |-> !tx_bit_valid_o ##1 !lead_done_o;
	endproperty
	a_lead_done: assert property (p_lead_done) else $error("lead done bad");
	property p_tail_done;
		tail_done_o |-> !tx_bit_valid_o ##1 !tail_done_o;
	endproperty
	a_tail_done: assert property (p_tail_done) else $error("tail done bad");
endmodule

bind energy_detect_and_tx_framing_config edtx_sva i_edtx_sva (.clk_i, .sys_rst_i,
	.reg_addr_i, .reg_rd_i, .reg_rdata_o, .quick_carrier_check_enable_i,
	.fast_check_done_i, .carrier_found_i, .goto_sleep_o, .goto_tx_on_o, .keep_receiving_o,
	.lead_start_i, .tail_start_i, .bit_req_i, .tx_bit_o, .tx_bit_valid_o, .lead_done_o,
	.tail_done_o);

// [verif/energy_detect_and_tx_framing_config_test.sv]
// Self-checking bench for the energy-detect and TX framing register bank.
// Assumes the checker is bound separately; the bench drives every port.
`timescale 1ns/10ps

module energy_detect_and_tx_framing_config_test;
	localparam logic [7:0] CTRL = edtx_pkg::ENERGY_CTRL_ADDR;
	localparam logic [7:0] TAIL = edtx_pkg::TAIL_CFG_ADDR;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic sample_valid_i = 1'b0;
	logic [7:0] sample_normal_i = 8'h00;
	logic [7:0] sample_wide_i = 8'h5a;
	logic calc_halt_i = 1'b0;
	logic quick_carrier_check_enable_i = 1'b0;
	logic fast_check_active_i = 1'b0;
	logic fast_check_done_i = 1'b0;
	logic carrier_found_i = 1'b0;
	logic sync_detected_i = 1'b0;
	logic rx_fifo_read_i = 1'b0;
	logic [3:0] lead_pattern_i = 4'h5;
	logic lead_start_i = 1'b0;
	logic tail_start_i = 1'b0;
	logic [1:0] crc_tail_i = 2'h2;
	logic bit_req_i = 1'b0;
	logic [7:0] reg_rdata_o, energy_value_o;
	logic goto_sleep_o, goto_tx_on_o, keep_receiving_o;
	logic tx_bit_o, tx_bit_valid_o, lead_done_o, tail_done_o;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	logic [2:0] e;

	energy_detect_and_tx_framing_config i_energy_detect_and_tx_framing_config (.clk_i,
		.sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.sample_valid_i, .sample_normal_i, .sample_wide_i, .calc_halt_i,
		.quick_carrier_check_enable_i, .fast_check_active_i, .fast_check_done_i,
		.carrier_found_i, .sync_detected_i, .rx_fifo_read_i, .energy_value_o, .goto_sleep_o,
		.goto_tx_on_o, .keep_receiving_o, .lead_pattern_i, .lead_start_i, .tail_start_i,
		.crc_tail_i, .bit_req_i, .tx_bit_o, .tx_bit_valid_o, .lead_done_o, .tail_done_o);

	// 50 MHz clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Register port: strobe for one edge, read data lands on that edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i) #1;
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i) #1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i) #1;
		reg_rd_i = 1'b0;
		chk8(reg_rdata_o, exp);
	endtask

	// Samples 2*i, so averaging n of them from zero gives n-1
	task automatic feed(input int first, input int cnt);
		for (int i = first; i < first + cnt; i++) begin
			sample_normal_i = 8'(2 * i);
			sample_valid_i = 1'b1;
			@(posedge clk_i) #1;
		end
		sample_valid_i = 1'b0;
	endtask

	// Start a lead or tail and consume n bits; every pattern repeats every four bits
	task automatic frame(input logic lead, input int n, input logic [3:0] pat);
		@(posedge clk_i) #1;
		lead_start_i = lead;
		tail_start_i = !lead;
		@(posedge clk_i) #1;
		lead_start_i = 1'b0;
		tail_start_i = 1'b0;
		if (n > 0)
			bit_req_i = 1'b1;
		for (int k = 0; k < n; k++) begin
			chk8({6'h00, tx_bit_valid_o, tx_bit_o}, {7'h01, pat[3 - k % 4]});
			@(posedge clk_i) #1;
		end
		bit_req_i = 1'b0;
		chk8({6'h00, tx_bit_valid_o, lead ? lead_done_o : tail_done_o}, 8'h01);
	endtask

	// Hang guard, generous against roughly 820 cycles of tests
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			$display("BAD t=%0t timeout", $time);
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		rd(CTRL, edtx_pkg::ENERGY_CTRL_RST);
		rd(8'h42, edtx_pkg::LEAD_HI_RST);
		rd(8'h43, edtx_pkg::LEAD_LO_RST);
		rd(TAIL, edtx_pkg::TAIL_CFG_RST);
		rd(8'h40, 8'h00);
		wr(TAIL, 8'hff);
		rd(TAIL, 8'h77);
		wr(8'h45, 8'hff);
		rd(8'h45, 8'h00);
		$display("test registers done");
		bit_req_i = 1'b1;
		@(posedge clk_i) #1;
		bit_req_i = 1'b0;
		chk8({7'h00, tx_bit_valid_o}, 8'h00);
		for (int p = 0; p < 4; p++) begin
			wr(TAIL, {4'h3, 1'b0, 2'(p), 1'b1});
			frame(0, 6, p == 0 ? 4'h5 : p == 1 ? 4'ha : p == 2 ? {crc_tail_i, ~crc_tail_i} : 4'hf);
		end
		wr(TAIL, 8'h30);
		frame(0, 0, 4'h0);
		wr(TAIL, 8'h01);
		frame(0, 0, 4'h0);
		wr(8'h42, 8'h01);
		wr(8'h43, 8'h02);
		lead_pattern_i = 4'h6;
		frame(1, 516, 4'h6);
		wr(8'h42, 8'h00);
		wr(8'h43, 8'h00);
		frame(1, 0, 4'h0);
		$display("test framing done");
		for (int c = 0; c < 8; c++) begin
			n = (c > 5) ? 16 : (1 << c);
			wr(CTRL, 8'(c));
			wr(CTRL, 8'(8'h80 | c));
			feed(0, n - 1);
			rd(CTRL, 8'(8'h80 | c));
			feed(n - 1, 1);
			rd(CTRL, 8'(8'h90 | c));
			chk8(energy_value_o, 8'(n - 1));
		end
		fast_check_active_i = 1'b1;
		wr(CTRL, 8'h00);
		wr(CTRL, 8'ha0);
		feed(3, 1);
		rd(CTRL, 8'hb0);
		chk8(energy_value_o, 8'h5a);
		wr(CTRL, 8'h00);
		wr(CTRL, 8'h80);
		feed(3, 1);
		rd(CTRL, 8'h90);
		chk8(energy_value_o, 8'h06);
		fast_check_active_i = 1'b0;
		wr(CTRL, 8'h88);
		feed(4, 1);
		rd(CTRL, 8'h98);
		chk8(energy_value_o, 8'h06);
		sync_detected_i = 1'b1;
		@(posedge clk_i) #1;
		sync_detected_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk8(energy_value_o, 8'h06);
		rx_fifo_read_i = 1'b1;
		@(posedge clk_i) #1;
		rx_fifo_read_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk8(energy_value_o, 8'h08);
		wr(CTRL, 8'h00);
		feed(5, 1);
		rd(CTRL, 8'h00);
		wr(CTRL, 8'h80);
		calc_halt_i = 1'b1;
		feed(5, 1);
		rd(CTRL, 8'h80);
		calc_halt_i = 1'b0;
		$display("test energy done");
		for (int c = 0; c < 8; c++) begin
			wr(CTRL, {1'b1, c[1], 6'h00});
			quick_carrier_check_enable_i = c[2];
			carrier_found_i = c[0];
			fast_check_done_i = 1'b1;
			@(posedge clk_i) #1;
			fast_check_done_i = 1'b0;
			e = !c[2] ? 3'b000 : c[1] ? (c[0] ? 3'b100 : 3'b010) : (c[0] ? 3'b001 : 3'b100);
			chk8({5'h00, goto_sleep_o, goto_tx_on_o, keep_receiving_o}, {5'h00, e});
		end
		$display("test quick check done");
		close_out();
	end
endmodule
